// ---- design/rsw_pkg.sv ----
// Purpose: Shared constants and types for the reset, sleep and wake block.
// Assumes: 200 MHz clock; 8-bit registers on 32-bit Wishbone words.
// Notes: Offsets are byte addresses of aligned words.
`default_nettype none
package rsw_pkg;
  localparam int CLK_KHZ = 200000;
  localparam int HOLD_MS = 18;
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam int IRC_SHORT_CYC = 8;
  localparam int IRC_LONG_CYC = 32;
  localparam int WAIT_W = 24;

  localparam logic [7:0] OFS_TICK_CTRL = 8'h00;
  localparam logic [7:0] OFS_TICK_CNT = 8'h04;
  localparam logic [7:0] OFS_DOG_CTRL = 8'h08;
  localparam logic [7:0] OFS_WAKE_CTRL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DOG_CNT = 8'h14;

  localparam int RATIO_LSB = 0;
  localparam int PRESC_BIT = 3;
  localparam int DC_LVR_BIT = 6;
  localparam int DC_EN_BIT = 7;
  localparam int WK_IRC_BIT = 5;
  localparam int WK_IRC32_BIT = 6;
  localparam int ST_GIE_BIT = 0;
  localparam int ST_SLEEP_BIT = 1;
  localparam int ST_HOLD_BIT = 2;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TOUT_BIT = 4;

  localparam logic [7:0] TICK_CTRL_RST = 8'h00;
  localparam logic [7:0] DOG_CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_CTRL_RST = 8'h00;
  localparam logic [7:0] DOG_KEEP_MASK = 8'h40;
  localparam logic [7:0] WAKE_KEEP_MASK = 8'h60;
  localparam logic [7:0] TICK_CNT_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'b100;

  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [PC_W-1:0] VEC_EXT = 12'h003;
  localparam logic [PC_W-1:0] VEC_PORT = 12'h006;
  localparam logic [PC_W-1:0] VEC_SPI = 12'h02a;
  localparam logic [PC_W-1:0] VEC_I2C = 12'h033;
  localparam logic [PC_W-1:0] VEC_ADC = 12'h03c;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10,
    ST_WAKE = 2'b11
  } rsw_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rsw_wb_req_t;

  // Order matches wake enable bits [4:0]
  typedef struct packed {
    logic ext_pin;
    logic port_chg;
    logic spi_rx;
    logic i2c_rx;
    logic adc_done;
  } rsw_wake_ev_t;
endpackage
`default_nettype wire

// ---- design/rsw_top.sv ----
// Purpose: Reset sources, reset hold, sleep/wake, tick counter, watchdog.
// Assumes: One instruction per clock; core instructions arrive as pulses.
// Notes: Watchdog oscillator and reset/low-voltage pins are sampled.
//
// Operation
// - Two 8-bit prescalers; tick ratio from 3-bit field of tick control.
// - Watchdog prescaler ratio from 3-bit field of watchdog control.
// - Writing the tick counter clears the tick prescaler.
// - Watchdog clear or sleep instruction clears dog count and prescaler.
// - Tick counter runs on instruction clock, plus one per cycle unscaled.
// - Tick counter holds its value during sleep.
// - Watchdog runs on its own oscillator, also in sleep; resets on expiry.
// - Software may enable or disable the watchdog any time in normal run.
// - Unscaled watchdog period equals one start-up period, about 18 ms.
// - Reset from power-on, pin low, watchdog expiry, or enabled low voltage.
// - Core stays in reset about 18 ms after any reset.
// - With internal RC oscillator the reset hold is 8 or 32 clocks.
// - Reset zeroes program counter, floats ports, clears dog, loads defaults.
// - Sleep instruction powers down; enabled watchdog cleared, keeps running.
// - With internal RC oscillator the wake delay is 8 or 32 clocks.
// - Pin, watchdog and five enabled event sources wake from sleep.
// - Pin or watchdog wake resets; time-out and power-down flags record it.
// - Other five sources continue; global interrupt state decides the branch.
// - Enabled interrupts branch to vectors 0x03-0x3C, else next instruction.
// - With watchdog enabled in sleep only pin, watchdog or enabled low voltage can wake.
`timescale 1ns/1ps
`default_nettype none
module rsw_top
  import rsw_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire rsw_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_rst_n_i,
  input wire logic dog_osc_i,
  input wire logic low_volt_i,
  input wire logic dog_clear_instr_i,
  input wire logic sleep_instr_i,
  input wire logic global_irq_on_instr_i,
  input wire logic global_irq_off_instr_i,
  input wire rsw_wake_ev_t wake_ev_i,
  output logic core_rst_o,
  output logic sleep_o,
  output logic osc_run_o,
  output logic port_in_mode_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_target_o,
  output logic [7:0] tick_count_o
);

  function automatic logic presc_hit(input logic [7:0] cnt,
                                     input logic [2:0] sel);
    logic [8:0] m;
    m = 9'h002 << sel;
    presc_hit = (cnt & (m[7:0] - 8'h01)) == (m[7:0] - 8'h01);
  endfunction

  rsw_state_t state_r;
  logic [WAIT_W-1:0] wait_r;
  logic [2:0] sync_a_r, sync_b_r, sync_c_r, stable_r;
  logic osc_prev_r;
  logic [7:0] tick_ctrl_r, dog_ctrl_r, wake_ctrl_r;
  logic [7:0] tick_pre_r, tick_cnt_r, dog_pre_r, dog_cnt_r;
  logic gie_r, tout_r, pd_r, ack_r, pc_load_r, branch_r;
  logic [PC_W-1:0] vec_r, pc_target_r;
  logic [31:0] dat_r;

  logic pin_low, osc_rise, lvd_lvl, dog_en, dog_clr, dog_step, dog_expire;
  logic rst_evt, cont_wake, wr, req, tick_step, hold_done;
  logic [WAIT_W-1:0] hold_len;
  logic [7:0] rd_val;
  logic [4:0] wake_hits;
  logic [PC_W-1:0] wake_vec;

  // Bit 2 reset pin, bit 1 watchdog oscillator, bit 0 low-voltage detect
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a_r <= SYNC_RST;
      sync_b_r <= SYNC_RST;
      sync_c_r <= SYNC_RST;
      stable_r <= SYNC_RST;
    end else begin
      sync_a_r <= {ext_rst_n_i, dog_osc_i, low_volt_i};
      sync_b_r <= sync_a_r;
      sync_c_r <= sync_b_r;
      // A change is taken only once the last two stages agree
      stable_r <= (sync_c_r & ~(sync_b_r ^ sync_c_r)) |
                  (stable_r & (sync_b_r ^ sync_c_r));
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= stable_r[1];
    end
  end

  assign pin_low = ~stable_r[2];
  assign osc_rise = stable_r[1] & ~osc_prev_r;
  assign lvd_lvl = stable_r[0];
  assign dog_en = dog_ctrl_r[DC_EN_BIT];
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
  assign wr = req & wb_req_i.we & wb_req_i.sel[0];

  // Watchdog clear sources
  assign dog_clr = (state_r == ST_HOLD) | dog_clear_instr_i |
                   (sleep_instr_i & (state_r == ST_RUN));
  assign dog_step = ~dog_ctrl_r[PRESC_BIT] |
                    presc_hit(dog_pre_r, dog_ctrl_r[RATIO_LSB +: 3]);
  // Unscaled, expiry comes after 256 oscillator edges, one start-up period
  assign dog_expire = dog_en & osc_rise & ~dog_clr & dog_step &
                      (dog_cnt_r == 8'hff);

  assign rst_evt = pin_low | dog_expire |
                   (dog_ctrl_r[DC_LVR_BIT] & lvd_lvl);

  assign wake_hits = wake_ev_i & wake_ctrl_r[4:0];
  // An enabled watchdog locks out the continuation sources
  assign cont_wake = (|wake_hits) & ~dog_en;

  always_comb begin
    if (wake_hits[4]) begin
      wake_vec = VEC_EXT;
    end else if (wake_hits[3]) begin
      wake_vec = VEC_PORT;
    end else if (wake_hits[2]) begin
      wake_vec = VEC_SPI;
    end else if (wake_hits[1]) begin
      wake_vec = VEC_I2C;
    end else begin
      wake_vec = VEC_ADC;
    end
  end

  always_comb begin
    if (!wake_ctrl_r[WK_IRC_BIT]) begin
      hold_len = WAIT_W'(HOLD_CYCLES);
    end else if (wake_ctrl_r[WK_IRC32_BIT]) begin
      hold_len = WAIT_W'(IRC_LONG_CYC);
    end else begin
      hold_len = WAIT_W'(IRC_SHORT_CYC);
    end
  end
  assign hold_done = wait_r >= (hold_len - WAIT_W'(1));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_HOLD;
      wait_r <= '0;
    end else begin
      case (state_r)
        ST_HOLD: begin
          if (rst_evt) begin
            wait_r <= '0;
          end else if (hold_done) begin
            state_r <= ST_RUN;
          end else begin
            wait_r <= wait_r + WAIT_W'(1);
          end
        end
        ST_RUN: begin
          wait_r <= '0;
          if (rst_evt) begin
            state_r <= ST_HOLD;
          end else if (sleep_instr_i) begin
            state_r <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          wait_r <= '0;
          if (rst_evt) begin
            state_r <= ST_HOLD;
          end else if (cont_wake) begin
            state_r <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (rst_evt) begin
            state_r <= ST_HOLD;
            wait_r <= '0;
          end else if (hold_done) begin
            state_r <= ST_RUN;
          end else begin
            wait_r <= wait_r + WAIT_W'(1);
          end
        end
        default: begin
          state_r <= ST_HOLD;
          wait_r <= '0;
        end
      endcase
    end
  end

  // Vector and branch decision caught at the wake event
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_r <= PC_RESET;
      branch_r <= 1'b0;
    end else if (state_r == ST_SLEEP && cont_wake && !rst_evt) begin
      vec_r <= wake_vec;
      branch_r <= gie_r;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_load_r <= 1'b0;
      pc_target_r <= PC_RESET;
    end else if (state_r == ST_HOLD && !rst_evt && hold_done) begin
      pc_load_r <= 1'b1;
      pc_target_r <= PC_RESET;
    end else if (state_r == ST_WAKE && !rst_evt && hold_done) begin
      // Without interrupts the core simply resumes after the sleep
      pc_load_r <= branch_r;
      pc_target_r <= vec_r;
    end else begin
      pc_load_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gie_r <= 1'b0;
    end else if (state_r == ST_HOLD) begin
      gie_r <= 1'b0;
    end else if (global_irq_on_instr_i) begin
      gie_r <= 1'b1;
    end else if (global_irq_off_instr_i) begin
      gie_r <= 1'b0;
    end
  end

  // Flags survive the reset they describe; the set wins over the clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tout_r <= 1'b0;
      pd_r <= 1'b0;
    end else if (rst_evt && state_r != ST_HOLD) begin
      tout_r <= dog_expire;
      pd_r <= (state_r == ST_SLEEP) | (state_r == ST_WAKE);
    end else if (dog_clear_instr_i) begin
      tout_r <= 1'b0;
      pd_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dog_pre_r <= 8'h00;
      dog_cnt_r <= 8'h00;
    end else if (dog_clr) begin
      dog_pre_r <= 8'h00;
      dog_cnt_r <= 8'h00;
    end else if (osc_rise) begin
      // Runs in every state but the reset hold, sleep included
      dog_pre_r <= dog_pre_r + 8'h01;
      if (dog_step) begin
        dog_cnt_r <= dog_cnt_r + 8'h01;
      end
    end
  end

  assign tick_step = ~tick_ctrl_r[PRESC_BIT] |
                     presc_hit(tick_pre_r, tick_ctrl_r[RATIO_LSB +: 3]);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_pre_r <= 8'h00;
      tick_cnt_r <= TICK_CNT_RST;
    end else if (state_r == ST_HOLD) begin
      tick_pre_r <= 8'h00;
      tick_cnt_r <= TICK_CNT_RST;
    end else if (wr && wb_req_i.adr == OFS_TICK_CNT) begin
      tick_pre_r <= 8'h00;
      tick_cnt_r <= wb_req_i.dat[7:0];
    end else if (state_r == ST_RUN) begin
      // Halted in sleep and during the wake delay
      tick_pre_r <= tick_pre_r + 8'h01;
      if (tick_step) begin
        tick_cnt_r <= tick_cnt_r + 8'h01;
      end
    end
  end

  // Control registers fall back to defaults during any reset hold, except the kept low-voltage and RC oscillator bits
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_ctrl_r <= TICK_CTRL_RST;
      dog_ctrl_r <= DOG_CTRL_RST;
      wake_ctrl_r <= WAKE_CTRL_RST;
    end else if (state_r == ST_HOLD) begin
      tick_ctrl_r <= TICK_CTRL_RST;
      dog_ctrl_r <= DOG_CTRL_RST | (dog_ctrl_r & DOG_KEEP_MASK);
      wake_ctrl_r <= WAKE_CTRL_RST | (wake_ctrl_r & WAKE_KEEP_MASK);
    end else if (wr) begin
      case (wb_req_i.adr)
        OFS_TICK_CTRL: tick_ctrl_r <= wb_req_i.dat[7:0];
        OFS_DOG_CTRL: dog_ctrl_r <= wb_req_i.dat[7:0];
        OFS_WAKE_CTRL: wake_ctrl_r <= wb_req_i.dat[7:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (wb_req_i.adr)
      OFS_TICK_CTRL: rd_val = tick_ctrl_r;
      OFS_TICK_CNT: rd_val = tick_cnt_r;
      OFS_DOG_CTRL: rd_val = dog_ctrl_r;
      OFS_WAKE_CTRL: rd_val = wake_ctrl_r;
      OFS_STATUS: begin
        rd_val = 8'h00;
        rd_val[ST_GIE_BIT] = gie_r;
        rd_val[ST_SLEEP_BIT] = state_r == ST_SLEEP;
        rd_val[ST_HOLD_BIT] = state_r == ST_HOLD;
        rd_val[ST_PD_BIT] = pd_r;
        rd_val[ST_TOUT_BIT] = tout_r;
      end
      OFS_DOG_CNT: rd_val = dog_cnt_r;
      default: rd_val = 8'h00;
    endcase
  end

  // One wait state; unmapped addresses still answer, reading zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req && !wb_req_i.we) begin
        dat_r <= {24'h00_0000, rd_val};
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign core_rst_o = state_r == ST_HOLD;
  assign port_in_mode_o = state_r == ST_HOLD;
  assign sleep_o = state_r == ST_SLEEP;
  assign osc_run_o = state_r != ST_SLEEP;
  assign pc_load_o = pc_load_r;
  assign pc_target_o = pc_target_r;
  assign tick_count_o = tick_cnt_r;

endmodule
`default_nettype wire

// ---- test/rsw_top_asserts.sv ----
// Purpose: Port checks for the reset, sleep and wake block.
// Assumes: One clock; rst_i asynchronous, active high.
// Notes: Hold length is checked as a floor; the bench checks exact spans.
`timescale 1ns/1ps
`default_nettype none
module rsw_top_asserts
  import rsw_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire rsw_wb_req_t wb_req_i,
  input wire logic wb_ack_o,
  input wire logic ext_rst_n_i,
  input wire logic sleep_instr_i,
  input wire logic core_rst_o,
  input wire logic sleep_o,
  input wire logic osc_run_o,
  input wire logic port_in_mode_o,
  input wire logic pc_load_o,
  input wire logic [PC_W-1:0] pc_target_o,
  input wire logic [7:0] tick_count_o
);
  logic [3:0] hold_cnt_r;
  // Saturates so a long hold never wraps back under the floor
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt_r <= 4'h0;
    end else if (!core_rst_o) begin
      hold_cnt_r <= 4'h0;
    end else if (hold_cnt_r != 4'hf) begin
      hold_cnt_r <= hold_cnt_r + 4'h1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_bus_ack_once: assert property (
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack missing or longer than one cycle");
  a_ports_float: assert property (
    port_in_mode_o == core_rst_o)
    else $error("ports not floated together with core reset");
  a_osc_sleep: assert property (
    osc_run_o == !sleep_o)
    else $error("oscillator state disagrees with sleep");
  a_tick_frozen: assert property (
    sleep_o && $past(sleep_o) |-> $stable(tick_count_o))
    else $error("tick counter moved while asleep");
  a_sleep_entry: assert property (
    sleep_instr_i && ext_rst_n_i && !core_rst_o && !sleep_o |=> sleep_o)
    else $error("sleep instruction did not enter sleep");
  a_pin_reset: assert property (
    !ext_rst_n_i [*4] |-> ##[0:3] core_rst_o)
    else $error("reset pin low did not reset the core");
  a_reset_pc: assert property (
    $fell(core_rst_o) |-> ##[0:1] (pc_load_o && pc_target_o == PC_RESET))
    else $error("no load of the reset address after hold");
  a_hold_floor: assert property (
    core_rst_o && hold_cnt_r < 4'h7 |=> core_rst_o)
    else $error("core reset shorter than eight cycles");
endmodule
bind rsw_top rsw_top_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_ack_o(wb_ack_o), .ext_rst_n_i(ext_rst_n_i),
  .sleep_instr_i(sleep_instr_i), .core_rst_o(core_rst_o),
  .sleep_o(sleep_o), .osc_run_o(osc_run_o),
  .port_in_mode_o(port_in_mode_o), .pc_load_o(pc_load_o),
  .pc_target_o(pc_target_o), .tick_count_o(tick_count_o));
`default_nettype wire

// ---- test/test_rsw_top.sv ----
// Purpose: Self-checking bench for the reset, sleep and wake block.
// Assumes: Hold shortened to 20 cycles; inputs driven after rising edges.
// Notes: Hold spans compared as differences so pin sync latency cancels.
`timescale 1ns/1ps
`default_nettype none
module test_rsw_top;
  import rsw_pkg::*;
  localparam int HOLD = 20;
  localparam logic [11:0] VECS [5] = '{VEC_ADC, VEC_I2C, VEC_SPI,
    VEC_PORT, VEC_EXT};
  logic mclk = 1'b0, rst = 1'b1, ext_n = 1'b1, osc = 1'b0, lv = 1'b0;
  logic [3:0] op = 4'h0;
  rsw_wb_req_t req = '0;
  rsw_wake_ev_t wev = '0;
  logic ack, core_rst, sleep, pc_load;
  logic [31:0] rdat, q;
  logic [PC_W-1:0] pc_tgt;
  logic [7:0] tick, t0;
  int fails = 0, cmp_count = 0, n, n8, n20, n32;
  rsw_top #(.HOLD_CYCLES(HOLD)) dut_u (.mclk_i(mclk), .rst_i(rst),
    .wb_req_i(req), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_rst_n_i(ext_n),
    .dog_osc_i(osc), .low_volt_i(lv), .dog_clear_instr_i(op[2]),
    .sleep_instr_i(op[3]), .global_irq_on_instr_i(op[1]),
    .global_irq_off_instr_i(op[0]), .wake_ev_i(wev),
    .core_rst_o(core_rst), .sleep_o(sleep), .osc_run_o(),
    .port_in_mode_o(), .pc_load_o(pc_load), .pc_target_o(pc_tgt),
    .tick_count_o(tick));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Request held until the ack edge; read data is taken at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, d}};
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    req <= '0;
  endtask
  task automatic ins(input int k);
    @(posedge mclk);
    op <= 4'h8 >> k;
    @(posedge mclk);
    op <= 4'h0;
  endtask
  task automatic ev(input int b);
    @(posedge mclk);
    wev <= rsw_wake_ev_t'(5'h01 << b);
    @(posedge mclk);
    wev <= '0;
  endtask
  // Slow ticks so each level survives the synchroniser
  task automatic ticks(input int k);
    repeat (k) begin
      cyc(2);
      osc <= 1'b1;
      cyc(2);
      osc <= 1'b0;
    end
    // The last rise needs about five edges to pass the synchroniser
    cyc(4);
  endtask
  task automatic wait_run(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (core_rst !== 1'b0);
  endtask
  task automatic pin_rst(input logic [7:0] w, output int c);
    wb(1'b1, OFS_WAKE_CTRL, w);
    ext_n <= 1'b0;
    cyc(5);
    ext_n <= 1'b1;
    wait_run(c);
  endtask
  task automatic wake(input int b);
    ev(b);
    n = 0;
    while (pc_load !== 1'b1 && n < 80) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d errors=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_tick;
    t0 = tick;
    cyc(5);
    chk(8'(tick - t0), 8'h05);
    for (int r = 0; r < 8; r++) begin
      wb(1'b1, OFS_TICK_CTRL, 8'h08 | 8'(r));
      wb(1'b1, OFS_TICK_CNT, 8'h00);
      t0 = tick;
      cyc(4 << r);
      chk(8'(tick - t0), 8'h02);
    end
    cyc(150);
    wb(1'b1, OFS_TICK_CNT, 8'h50);
    cyc(200);
    chk(tick, 8'h50);
    cyc(70);
    chk(tick, 8'h51);
    wb(1'b1, OFS_TICK_CTRL, 8'h00);
  endtask
  task automatic t_sleep;
    for (int b = 0; b < 5; b++) begin
      ins(2);
      wb(1'b1, OFS_WAKE_CTRL, 8'h01 << b);
      ins(0);
      cyc(1);
      t0 = tick;
      ev((b + 1) % 5);
      cyc(4);
      chk(sleep, 1'b1);
      chk(tick, t0);
      wake(b);
      chk(n, HOLD + 1);
      chk(pc_tgt, VECS[b]);
    end
    ins(3);
    wb(1'b1, OFS_WAKE_CTRL, 8'h01);
    ins(0);
    wake(0);
    chk(n, 80);
    chk(sleep, 1'b0);
  endtask
  task automatic t_dog;
    wb(1'b1, OFS_DOG_CTRL, 8'h88);
    ins(1);
    ticks(4);
    wb(1'b0, OFS_DOG_CNT, 8'h00);
    chk(q, 32'h2);
    wb(1'b1, OFS_DOG_CTRL, 8'h80);
    ticks(3);
    ins(0);
    wb(1'b0, OFS_DOG_CNT, 8'h00);
    chk(q, 32'h0);
    ev(0);
    ticks(255);
    chk(sleep, 1'b1);
    ticks(1);
    cyc(6);
    chk(core_rst, 1'b1);
    wait_run(n);
    wb(1'b0, OFS_STATUS, 8'h00);
    chk(q, 32'h18);
  endtask
  task automatic t_pins;
    wb(1'b1, OFS_TICK_CTRL, 8'h0b);
    pin_rst(8'h00, n20);
    pin_rst(8'h20, n8);
    pin_rst(8'h60, n32);
    chk(n20 - n8, HOLD - 8);
    chk(n32 - n8, 24);
    wb(1'b0, OFS_TICK_CTRL, 8'h00);
    chk(q, 32'h0);
    wb(1'b1, 8'h20, 8'hff);
    wb(1'b0, 8'h20, 8'h00);
    chk(q, 32'h0);
  endtask
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    wait_run(n);
    t_tick();
    t_sleep();
    t_dog();
    t_pins();
    end_sim();
  end
  initial begin
    cyc(20000);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
